// >>> pe_pin_select_pkg.sv
// constants, field layouts and per-pin tables for the upper port e function select
// assumes one 40 mhz clock and a plain strobe-based register port
package pe_pin_select_pkg;
   // clock figures
   localparam int CLK_MHZ = 40; // system clock rate
   localparam int CLK_PERIOD_NS = 25; // system clock period
   // register port shape
   localparam int ADDR_W = 8; // byte address width
   localparam int DATA_W = 16; // register width
   localparam int NUM_PINS = 9; // pins 16 up to 24
   // byte offsets of the register words
   localparam logic [7:0] OFS_TOP_PIN_SELECT = 8'h00; // pin 24 field
   localparam logic [7:0] OFS_UPPER_PIN_SELECT = 8'h04; // pins 23..16 fields
   localparam logic [7:0] OFS_DIRECTION_HIGH = 8'h08; // gpio direction, pins 24..16
   localparam logic [7:0] OFS_PIN_LEVEL = 8'h0c; // sampled pin levels, read only
   // field positions
   localparam int TOP_FIELD_LSB = 0; // pin 24 field at bits 1:0
   localparam int MODE_W = 2; // bits per mode field
   // writable masks, reserved bits read as zero
   localparam logic [15:0] TOP_WR_MASK = 16'h0003; // bits 15..2 reserved
   localparam logic [15:0] UPPER_WR_MASK = 16'hffff; // all eight fields
   localparam logic [15:0] DIR_WR_MASK = 16'h01ff; // one bit per pin
   // values after reset, before the boot strap is applied
   localparam logic [15:0] TOP_RESET_VAL = 16'h0000; // general i/o
   localparam logic [15:0] UPPER_RESET_VAL = 16'h0000; // general i/o
   localparam logic [15:0] DIR_RESET_VAL = 16'h0000; // all inputs
   // values loaded when booting through the host interface
   localparam logic [15:0] TOP_BOOT_VAL = 16'h0001; // lower bit of the field set
   localparam logic [15:0] UPPER_BOOT_VAL = 16'h5555; // lower bit of each field set
   localparam logic [15:0] READ_ZERO = 16'h0000; // unmapped read answer
   // owners of a pin
   typedef enum logic [1:0] {
      MODE_GPIO = 2'b00, // general-purpose i/o
      MODE_HOST = 2'b01, // host interface data bit
      MODE_UART = 2'b10, // uart_with_fifo signal
      MODE_BUS = 2'b11 // external_bus_controller data bit
   } pin_mode_t;
   // direction of the uart signal on a pin
   typedef enum logic [1:0] {
      UART_IN = 2'b01, // pin feeds the uart
      UART_OUT = 2'b10, // uart drives the pin
      UART_BIDIR = 2'b11 // uart enables its own drive
   } uart_kind_t;
   // boot phase after reset release
   typedef enum logic {
      ST_BOOT = 1'b0, // strap not yet applied
      ST_RUN = 1'b1 // normal operation
   } boot_state_t;
   // uart signal kind per pin, index 0 is pin 16
   localparam logic [8:0][1:0] UART_KIND_TABLE = {
      UART_IN, // 24 uart1_clear_to_send
      UART_IN, // 23 uart1_request_to_send, listed as input
      UART_IN, // 22 uart0_clear_to_send
      UART_OUT, // 21 uart0_request_to_send
      UART_BIDIR, // 20 uart1_serial_clock
      UART_OUT, // 19 uart1_receive, listed as output
      UART_OUT, // 18 uart1_transmit
      UART_BIDIR, // 17 uart0_serial_clock
      UART_IN // 16 uart0_receive
   };
   // idle level fed to a uart input that is not routed, index 0 is pin 16
   localparam logic [8:0] UART_IDLE_TABLE = 9'h1c1;
   localparam logic SYNC_RELEASED = 1'b1; // synchroniser constant
endpackage

// >>> pe_reset_sync.sv
// two-stage release synchroniser for the active-low reset
// assumes the asynchronous reset input may drop at any time
module pe_reset_sync
   import pe_pin_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   // stage 0 feeds stage 1 only
   typedef struct packed {
      logic stage1; // second flop, the clean copy
      logic stage0; // first flop, may be metastable
   } sync_state_t;

   sync_state_t st_ff; // registered state
   sync_state_t nxt_st; // next state

   // shift a one in after release
   always_comb begin
      nxt_st.stage0 = SYNC_RELEASED;
      nxt_st.stage1 = st_ff.stage0;
   end

   // asserts at once, releases two edges later
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rst_sync_n = st_ff.stage1;
endmodule

// >>> pe_pin_route.sv
// routing for one multiplexed pin: picks the owner that drives it and feeds the pin level back to that owner only, except the uart on an output pin
// assumes each peripheral gives data and, where bidirectional, its own drive enable
module pe_pin_route
   import pe_pin_select_pkg::*;
#(
   parameter logic [1:0] UART_KIND = 2'b01,
   parameter logic UART_IDLE = 1'b1
)
(
   input wire logic [1:0] mode,
   input wire logic gpio_dir,
   input wire logic pin_in,
   input wire logic gpio_dout,
   input wire logic host_dout,
   input wire logic host_oe,
   input wire logic uart_dout,
   input wire logic uart_oe,
   input wire logic bus_dout,
   input wire logic bus_oe,
   output logic pin_out,
   output logic pin_oe,
   output logic gpio_din,
   output logic host_din,
   output logic uart_din,
   output logic bus_din
);
   // one owner at a time, the rest see their idle level
   always_comb begin
      pin_out = 1'b0;
      pin_oe = 1'b0;
      gpio_din = 1'b0;
      host_din = 1'b0;
      uart_din = UART_IDLE;
      bus_din = 1'b0;
      case (pin_mode_t'(mode))
         // port pin: direction register decides
         MODE_GPIO: begin
            pin_out = gpio_dout;
            pin_oe = gpio_dir;
            gpio_din = pin_in;
         end
         // host data bit, host controls its own drive
         MODE_HOST: begin
            pin_out = host_dout;
            pin_oe = host_oe;
            host_din = pin_in;
         end
         // uart signal, per-pin kind fixes the direction or leaves it to uart_oe
         MODE_UART: begin
            pin_out = uart_dout;
            if (UART_KIND == UART_OUT) begin
               pin_oe = 1'b1;
            end else if (UART_KIND == UART_BIDIR) begin
               pin_oe = uart_oe;
            end else begin
               pin_oe = 1'b0;
            end
            if (UART_KIND != UART_OUT) begin
               uart_din = pin_in;
            end
         end
         // external bus data bit
         default: begin
            pin_out = bus_dout;
            pin_oe = bus_oe;
            bus_din = pin_in;
         end
      endcase
   end
endmodule

// >>> pe_pin_select.sv
// top of the upper port e function select: registers, boot strap and nine pin routers
// assumes reads and writes arrive as one-cycle strobes synchronous to ref_clk
module pe_pin_select
   import pe_pin_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic host_boot,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [8:0] pin_in,
   output logic [8:0] pin_out,
   output logic [8:0] pin_oe,
   input wire logic [8:0] gpio_dout,
   output logic [8:0] gpio_din,
   input wire logic [8:0] host_dout,
   input wire logic [8:0] host_oe,
   output logic [8:0] host_din,
   input wire logic [8:0] uart_dout,
   input wire logic [8:0] uart_oe,
   output logic [8:0] uart_din,
   input wire logic [8:0] bus_dout,
   input wire logic [8:0] bus_oe,
   output logic [8:0] bus_din,
   output logic [17:0] pin_mode
);
   // whole state of the block
   typedef struct packed {
      boot_state_t phase; // strap applied or not
      logic [15:0] top_sel; // port_e_top_pin_select
      logic [15:0] upper_sel; // port_e_upper_pin_select
      logic [15:0] dir_high; // port_e_direction_high
      logic [15:0] rdata; // read data, valid one cycle
   } block_state_t;

   block_state_t st_ff; // registered state
   block_state_t nxt_st; // next state
   logic rst_sync_n; // released copy of the reset
   logic [8:0][1:0] modes; // per-pin mode, index 0 is pin 16

   // mode field of one pin out of the two select registers
   function automatic logic [1:0] field_of(
      input logic [15:0] top,
      input logic [15:0] upper,
      input int idx
   );
      logic [1:0] f;
      f = upper[(idx % 8) * MODE_W +: MODE_W];
      if (idx == 8) begin
         f = top[TOP_FIELD_LSB +: MODE_W];
      end
      return f;
   endfunction

   // merge a masked write into a register
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] wdata,
      input logic [15:0] mask
   );
      return (old & ~mask) | (wdata & mask);
   endfunction

   // reset release through two flops
   pe_reset_sync u_reset_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   // next-state logic: strap, writes and reads
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdata = READ_ZERO;
      // first cycle after release: apply the boot strap
      if (st_ff.phase == ST_BOOT) begin
         nxt_st.phase = ST_RUN;
         if (host_boot) begin
            nxt_st.top_sel = TOP_BOOT_VAL;
            nxt_st.upper_sel = UPPER_BOOT_VAL;
         end
      end
      // register writes, taking effect on the next edge
      if (reg_wr) begin
         if (reg_addr == OFS_TOP_PIN_SELECT) begin
            // reserved bits stay zero
            nxt_st.top_sel = merge(st_ff.top_sel, reg_wdata, TOP_WR_MASK);
         end else if (reg_addr == OFS_UPPER_PIN_SELECT) begin
            nxt_st.upper_sel = merge(st_ff.upper_sel, reg_wdata, UPPER_WR_MASK);
         end else if (reg_addr == OFS_DIRECTION_HIGH) begin
            nxt_st.dir_high = merge(st_ff.dir_high, reg_wdata, DIR_WR_MASK);
         end
      end
      // register reads, answered in the following cycle
      if (reg_rd) begin
         if (reg_addr == OFS_TOP_PIN_SELECT) begin
            // upper bits read as zero
            nxt_st.rdata = st_ff.top_sel & TOP_WR_MASK;
         end else if (reg_addr == OFS_UPPER_PIN_SELECT) begin
            nxt_st.rdata = st_ff.upper_sel;
         end else if (reg_addr == OFS_DIRECTION_HIGH) begin
            nxt_st.rdata = st_ff.dir_high & DIR_WR_MASK;
         end else if (reg_addr == OFS_PIN_LEVEL) begin
            // live pin levels, whoever owns them
            nxt_st.rdata = {7'h00, pin_in};
         end else begin
            // unmapped address reads zero
            nxt_st.rdata = READ_ZERO;
         end
      end
   end

   // state register, fields cleared before the strap
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_ff.phase <= ST_BOOT;
         st_ff.top_sel <= TOP_RESET_VAL;
         st_ff.upper_sel <= UPPER_RESET_VAL;
         st_ff.dir_high <= DIR_RESET_VAL;
         st_ff.rdata <= READ_ZERO;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;

   // per-pin routing, field decode straight from the registers
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      // pins 16..23 from the upper register, 24 from the top one
      assign modes[i] = field_of(st_ff.top_sel, st_ff.upper_sel, i);
      assign pin_mode[i * MODE_W +: MODE_W] = modes[i];

      pe_pin_route #(
         .UART_KIND(UART_KIND_TABLE[i]),
         .UART_IDLE(UART_IDLE_TABLE[i])
      ) u_route (
         .mode(modes[i]),
         .gpio_dir(st_ff.dir_high[i]),
         .pin_in(pin_in[i]),
         .gpio_dout(gpio_dout[i]),
         .host_dout(host_dout[i]),
         .host_oe(host_oe[i]),
         .uart_dout(uart_dout[i]),
         .uart_oe(uart_oe[i]),
         .bus_dout(bus_dout[i]),
         .bus_oe(bus_oe[i]),
         .pin_out(pin_out[i]),
         .pin_oe(pin_oe[i]),
         .gpio_din(gpio_din[i]),
         .host_din(host_din[i]),
         .uart_din(uart_din[i]),
         .bus_din(bus_din[i])
      );
   end
endmodule

// >>> pe_pin_select_properties.sv
// concurrent checks on the upper port e function select
// assumes it is bound to pe_pin_select and sees only its ports
module pe_pin_select_properties
   import pe_pin_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic host_boot,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [8:0] pin_in,
   input wire logic [8:0] pin_oe,
   input wire logic [8:0] gpio_din,
   input wire logic [8:0] host_oe,
   input wire logic [8:0] host_din,
   input wire logic [8:0] uart_din,
   input wire logic [8:0] bus_din,
   input wire logic [17:0] pin_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [8:0] m_gp, m_ho, m_ua, m_bu; // owner masks per pin
   logic [8:0] dir_ff; // shadow of the direction word
   // decode each mode field into owner masks
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         m_gp[i] = pin_mode[2*i+:2] == 2'b00;
         m_ho[i] = pin_mode[2*i+:2] == 2'b01;
         m_ua[i] = pin_mode[2*i+:2] == 2'b10;
         m_bu[i] = pin_mode[2*i+:2] == 2'b11;
      end
   end
   // follow software writes to the direction word
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_ff <= 9'h000;
      end else if (reg_wr && reg_addr == OFS_DIRECTION_HIGH) begin
         dir_ff <= reg_wdata[8:0];
      end
   end
   // release seen, strap applied two edges later
   sequence boot_done_s;
      $rose(rst_n) ##3 1'b1;
   endsequence
   strap_reset_a: assert property (boot_done_s |-> pin_mode == (host_boot ? 18'h15555 : 18'h00000))
      else $error("select fields wrong after reset");
   top_write_a: assert property (reg_wr && reg_addr == OFS_TOP_PIN_SELECT |=>
      pin_mode[17:16] == $past(reg_wdata[1:0])) else $error("top field not taken");
   upper_write_a: assert property (reg_wr && reg_addr == OFS_UPPER_PIN_SELECT |=>
      pin_mode[15:0] == $past(reg_wdata)) else $error("upper fields not taken");
   top_reserved_a: assert property (reg_rd && reg_addr == OFS_TOP_PIN_SELECT |=>
      reg_rdata == {14'h0000, pin_mode[17:16]}) else $error("top word read wrong");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   host_route_a: assert property (host_din == (pin_in & m_ho) && (pin_oe & m_ho) == (host_oe & m_ho))
      else $error("host routing wrong");
   gpio_route_a: assert property (gpio_din == (pin_in & m_gp) && (pin_oe & m_gp) == (dir_ff & m_gp))
      else $error("port routing wrong");
   bus_route_a: assert property (bus_din == (pin_in & m_bu))
      else $error("bus routing wrong");
   uart_idle_a: assert property ((uart_din & ~m_ua) == (UART_IDLE_TABLE & ~m_ua))
      else $error("unrouted uart input not idle");
endmodule

bind pe_pin_select pe_pin_select_properties i_props (.ref_clk, .rst_n, .host_boot, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_oe, .gpio_din, .host_oe, .host_din,
   .uart_din, .bus_din, .pin_mode);

// >>> pe_pad_model.sv
// board side of the nine upper port e pads
// assumes no pull resistors: an undriven pad shows the level the bench sets
module pe_pad_model (
   input wire logic [8:0] pin_out,
   input wire logic [8:0] pin_oe,
   input wire logic [8:0] ext_level,
   output logic [8:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // chip drive wins, else the board level
   always_comb begin
      pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
   end
endmodule

// >>> tb_top.sv
// self-checking bench for the upper port e function select
// assumes the pad model closes the pins and the checker is bound to the design
module tb_top;
   import pe_pin_select_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n, host_boot, reg_wr, reg_rd, rd_d;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, top_s, up_s, dir_s; // shadows of the words
   logic [8:0] pin_in, pin_out, pin_oe, gpio_din, host_din, uart_din, bus_din;
   logic [8:0] gpio_dout, host_dout, host_oe, uart_dout, uart_oe, bus_dout, bus_oe, ext;
   logic [17:0] pin_mode;
   logic [15:0] rd_q[$]; // expected read words
   logic [53:0] pin_q[$]; // expected pin pictures
   logic [53:0] pic; // latest expected pin picture
   int fail_count = 0;
   int n_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   pe_pin_select i_dut (.ref_clk, .rst_n, .host_boot, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pin_in, .pin_out, .pin_oe, .gpio_dout, .gpio_din, .host_dout, .host_oe,
      .host_din, .uart_dout, .uart_oe, .uart_din, .bus_dout, .bus_oe, .bus_din, .pin_mode);
   pe_pad_model i_pads (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
   // expected pins from the shadows and peripheral drives
   function automatic logic [53:0] exp_pins();
      logic [17:0] md;
      logic [8:0] oe, o, pi, gi, hi, ui, bi;
      logic [1:0] k;
      md = {top_s[1:0], up_s};
      for (int i = 0; i < 9; i++) begin
         k = UART_KIND_TABLE[i];
         case (md[2*i+:2])
            2'b00: {oe[i], o[i]} = {dir_s[i], gpio_dout[i]};
            2'b01: {oe[i], o[i]} = {host_oe[i], host_dout[i]};
            2'b10: {oe[i], o[i]} = {k == UART_OUT || (k == UART_BIDIR && uart_oe[i]), uart_dout[i]};
            default: {oe[i], o[i]} = {bus_oe[i], bus_dout[i]};
         endcase
         pi[i] = oe[i] ? o[i] : ext[i];
         gi[i] = md[2*i+:2] == 2'b00 && pi[i];
         hi[i] = md[2*i+:2] == 2'b01 && pi[i];
         bi[i] = md[2*i+:2] == 2'b11 && pi[i];
         ui[i] = (md[2*i+:2] == 2'b10 && k != UART_OUT) ? pi[i] : UART_IDLE_TABLE[i];
      end
      return {oe, o & oe, gi, hi, ui, bi};
   endfunction
   task chk_rd(input logic [15:0] e, input logic [15:0] a);
      n_checks++;
      if (a !== e) begin
         fail_count++;
         $display("ERROR %0t read word %h expected %h", $time, a, e);
      end
   endtask
   task chk_pins(input logic [53:0] e, input logic [53:0] a);
      n_checks++;
      if (a !== e) begin
         fail_count++;
         $display("ERROR %0t pins %h expected %h", $time, a, e);
      end
   endtask
   // read word compared in the cycle after its strobe
   always @(posedge ref_clk) begin
      if (rd_d) chk_rd(rd_q.pop_front(), reg_rdata);
      rd_d = reg_rd;
   end
   // pin picture compared mid-cycle after each note
   always @(negedge ref_clk) begin
      if (pin_q.size() > 0) chk_pins(pin_q.pop_front(),
         {pin_oe, pin_out & pin_oe, gpio_din, host_din, uart_din, bus_din});
   end
   task wr(input logic [7:0] a, input logic [15:0] d);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
      @(posedge ref_clk);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
      @(posedge ref_clk);
   endtask
   task idle;
      {reg_wr, reg_rd} <= 2'b00;
      @(posedge ref_clk);
   endtask
   task end_test(input string name);
      $display("test %s done", name);
   endtask
   // reset with a given strap, then check the two select words and the pins
   task do_reset(input logic hb);
      @(posedge ref_clk);
      {host_boot, rst_n} <= {hb, 1'b0};
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      top_s = hb ? TOP_BOOT_VAL : TOP_RESET_VAL;
      up_s = hb ? UPPER_BOOT_VAL : UPPER_RESET_VAL;
      dir_s = DIR_RESET_VAL;
      rd(OFS_TOP_PIN_SELECT, top_s);
      rd(OFS_UPPER_PIN_SELECT, up_s);
      idle;
      pin_q.push_back(exp_pins());
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {rst_n, host_boot, reg_wr, reg_rd, reg_addr, reg_wdata, rd_d} = '0;
      {gpio_dout, host_dout, host_oe, uart_dout, uart_oe, bus_dout, bus_oe, ext} = '0;
      void'($urandom(32'hcde81b64));
      do_reset(1'b1);
      end_test("boot strap");
      // reserved bits kept zero by software, unmapped place back to back
      wr(OFS_TOP_PIN_SELECT, 16'h0002);
      wr(OFS_UPPER_PIN_SELECT, 16'h1b1b);
      wr(8'h10, 16'hffff);
      rd(OFS_TOP_PIN_SELECT, 16'h0002);
      rd(OFS_UPPER_PIN_SELECT, 16'h1b1b);
      rd(8'h10, READ_ZERO);
      idle;
      end_test("register access");
      // one owner on all pins first, then random mixes
      for (int i = 0; i < 24; i++) begin
         {gpio_dout, host_dout, host_oe, uart_dout, uart_oe, bus_dout, bus_oe, ext} <=
            72'({$urandom(), $urandom(), $urandom()});
         dir_s = 16'($urandom()) & DIR_WR_MASK;
         top_s = i < 4 ? 16'(i) : 16'($urandom()) & TOP_WR_MASK;
         up_s = i < 4 ? {8{2'(i)}} : 16'($urandom());
         wr(OFS_DIRECTION_HIGH, dir_s);
         wr(OFS_TOP_PIN_SELECT, top_s);
         wr(OFS_UPPER_PIN_SELECT, up_s);
         pic = exp_pins();
         pin_q.push_back(pic);
         rd(OFS_PIN_LEVEL, {7'h00, pic[44:36] | (ext & ~pic[53:45])});
         rd(OFS_UPPER_PIN_SELECT, up_s);
         rd(OFS_DIRECTION_HIGH, dir_s);
         idle;
      end
      end_test("pin routing");
      do_reset(1'b0);
      end_test("second reset");
      // let the last read and pin picture be compared
      repeat (2) idle;
      give_verdict;
   end
   // cut a hang short
   initial begin
      #(CLK_PERIOD_NS * 3000);
      fail_count++;
      give_verdict;
   end
endmodule
